//--- logic/qpd_pkg.sv
// shared constants and types for the quad-pumped data bus slice
// assumes both agents share one clk; pins are active low, idle high by pull-up
package qpd_pkg;
	localparam int DATA_W           = 64;
	localparam int GRP_W            = 16;
	localparam int GROUPS           = 4;
	localparam int XFERS            = 4;   // transfers per common bus period
	localparam int HALF_GRP         = GRP_W / 2;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int STROBE_PERIOD_NS = 32;
	// one strobe period carries two transfers (one per strobe of the pair)
	localparam int XFER_CYC         = STROBE_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int STB_AT           = XFER_CYC / 2;  // strobe edge inside a transfer
	localparam int TAIL_CYC         = 4;   // busy held after last strobe edge
	localparam int CNT_W            = 3;
	localparam int XIDX_W           = 2;

	typedef logic [XFERS-1:0][DATA_W-1:0] qpd_block_t;

	typedef struct packed {
		logic [DATA_W-1:0] data_lines_n;
		logic [GROUPS-1:0] group_strobe_pos_n;
		logic [GROUPS-1:0] group_strobe_neg_n;
		logic [GROUPS-1:0] group_polarity_flags_n;
		logic              data_valid_indication_n;
		logic              data_bus_in_use_n;
	} qpd_pins_t;

	typedef enum logic [1:0] {
		QPD_IDLE  = 2'b00,
		QPD_ARB   = 2'b01,
		QPD_DRIVE = 2'b10,
		QPD_TAIL  = 2'b11
	} qpd_tx_state_t;
endpackage

//--- logic/qpd_bus_if.sv
// point-to-point data bus between the processor end and the hub end
// resolves the shared lines from each end's drive and enable; undriven lines idle high
`timescale 1ns/1ps
interface qpd_bus_if;
	import qpd_pkg::*;
	qpd_pins_t cpu_out;
	logic      cpu_oe;
	logic      cpu_busy_oe;
	qpd_pins_t hub_out;
	logic      hub_oe;
	logic      hub_busy_oe;
	qpd_pins_t lines;
	logic      busy_lv;

	// busy line is wired: low if either end pulls it
	assign busy_lv = ~((cpu_busy_oe & ~cpu_out.data_bus_in_use_n) |
		(hub_busy_oe & ~hub_out.data_bus_in_use_n));

	always_comb begin
		if (cpu_oe) begin
			lines = cpu_out;
		end else if (hub_oe) begin
			lines = hub_out;
		end else begin
			lines = '1;
		end
		lines.data_bus_in_use_n = busy_lv;
	end

	modport cpu (output cpu_out, output cpu_oe, output cpu_busy_oe, input lines);
	modport hub (output hub_out, output hub_oe, output hub_busy_oe, input lines);
endinterface

//--- logic/qpd_cpu_end.sv
// bus agent core (transmit and receive) and the processor end of the data bus
// assumes pins arrive from the other agent unsynchronised; all logic on clk
//
// Summary of operation
// - 64-bit shared two-way data path, point to point
// - driver asserts data valid on every transfer
// - four transfers per common bus period
// - capture on falling edge of either strobe
// - four 16-bit groups, own strobe and flag
// - flag active: group sampled active high
// - invert group when over half bits change
// - busy held while driving; free after release
`timescale 1ns/1ps
module qpd_agent (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// pins
	input  wire qpd_pkg::qpd_pins_t  pin_in,
	output qpd_pkg::qpd_pins_t       pin_out,
	output logic                     pin_oe,
	output logic                     busy_oe,
	// transmit side
	input  wire logic                tx_valid,
	input  wire qpd_pkg::qpd_block_t tx_block,
	output logic                     tx_ready,
	// receive side
	output logic                     rx_valid,
	output qpd_pkg::qpd_block_t      rx_block
);
	import qpd_pkg::*;

	typedef struct packed {
		qpd_tx_state_t               tx_st;
		logic [CNT_W-1:0]            cyc;
		logic [XIDX_W-1:0]           xfer;
		qpd_block_t                  txb;
		logic [DATA_W-1:0]           prev;
		qpd_pins_t                   po;
		logic                        drv_oe;
		logic                        busy_oe;
		logic                        tx_ready;
		qpd_pins_t                   s1;
		qpd_pins_t                   s2;
		logic [GROUPS-1:0]           pos_d;
		logic [GROUPS-1:0]           neg_d;
		logic [GROUPS-1:0][XIDX_W-1:0] slot;
		logic [GROUPS-1:0]           done;
		qpd_block_t                  asm_b;
		logic                        rx_valid;
		qpd_block_t                  rxb;
	} qpd_agent_st_t;

	qpd_agent_st_t st_reg;
	qpd_agent_st_t st_next;

	// count of ones in a group, for the inversion decision
	function automatic logic [4:0] qpd_ones(input logic [GRP_W-1:0] v);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < GRP_W; i++) begin
			n = n + 5'(v[i]);
		end
		return n;
	endfunction

	// next state: transmitter, synchroniser, receiver
	always_comb begin
		logic [GRP_W-1:0]  cand;
		logic [GRP_W-1:0]  val;
		logic [GROUPS-1:0] fall;
		logic [GROUPS-1:0] set_done;
		logic              tx_on;
		st_next  = st_reg;
		cand     = '0;
		val      = '0;
		fall     = '0;
		set_done = '0;
		tx_on    = (st_reg.tx_st != QPD_IDLE);

		// transmitter
		unique case (st_reg.tx_st)
			QPD_IDLE: begin
				if (tx_valid && st_reg.tx_ready) begin
					st_next.txb      = tx_block;
					st_next.tx_ready = 1'b0;
					st_next.tx_st    = QPD_ARB;
				end
			end
			QPD_ARB: begin
				// wait until nobody holds the data path
				if (st_reg.s2.data_bus_in_use_n && st_reg.s2.data_valid_indication_n) begin
					st_next.drv_oe               = 1'b1;
					st_next.busy_oe              = 1'b1;
					st_next.po.data_bus_in_use_n = 1'b0;
					st_next.cyc                  = '0;
					st_next.xfer                 = '0;
					st_next.prev                 = '1; // bus idled high
					st_next.tx_st                = QPD_DRIVE;
				end
			end
			QPD_DRIVE: begin
				st_next.cyc = st_reg.cyc + CNT_W'(1);
				if (st_reg.cyc == '0) begin
					// place one transfer, group by group
					for (int g = 0; g < GROUPS; g++) begin
						cand = ~st_reg.txb[st_reg.xfer][g*GRP_W +: GRP_W];
						if (qpd_ones(cand ^ st_reg.prev[g*GRP_W +: GRP_W]) > 5'(HALF_GRP)) begin
							cand                            = ~cand;
							st_next.po.group_polarity_flags_n[g] = 1'b0;
						end else begin
							st_next.po.group_polarity_flags_n[g] = 1'b1;
						end
						st_next.po.data_lines_n[g*GRP_W +: GRP_W] = cand;
						st_next.prev[g*GRP_W +: GRP_W]            = cand;
					end
					st_next.po.data_valid_indication_n = 1'b0;
				end
				// even transfers fall on the positive strobe, odd on the negative
				if (st_reg.cyc == CNT_W'(STB_AT)) begin
					if (!st_reg.xfer[0]) begin
						st_next.po.group_strobe_pos_n = '0;
						st_next.po.group_strobe_neg_n = '1;
					end else begin
						st_next.po.group_strobe_neg_n = '0;
						st_next.po.group_strobe_pos_n = '1;
					end
				end
				if (st_reg.cyc == CNT_W'(XFER_CYC - 1)) begin
					st_next.cyc = '0;
					if (st_reg.xfer == XIDX_W'(XFERS - 1)) begin
						st_next.po.data_valid_indication_n = 1'b1;
						st_next.po.group_strobe_neg_n      = '1;
						st_next.tx_st                      = QPD_TAIL;
					end else begin
						st_next.xfer = st_reg.xfer + XIDX_W'(1);
					end
				end
			end
			QPD_TAIL: begin
				// busy outlives the last edge so the far end sees it all
				st_next.cyc = st_reg.cyc + CNT_W'(1);
				if (st_reg.cyc == CNT_W'(TAIL_CYC - 1)) begin
					st_next.drv_oe               = 1'b0;
					st_next.busy_oe              = 1'b0;
					st_next.po                   = '1;
					st_next.po.data_bus_in_use_n = 1'b1;
					st_next.tx_ready             = 1'b1;
					st_next.tx_st                = QPD_IDLE;
				end
			end
		endcase

		// two-flop synchroniser; s1 feeds s2 only
		st_next.s1    = pin_in;
		st_next.s2    = st_reg.s1;
		st_next.pos_d = st_reg.s2.group_strobe_pos_n;
		st_next.neg_d = st_reg.s2.group_strobe_neg_n;

		// receiver: own transfers are ignored while transmitting
		st_next.rx_valid = 1'b0;
		for (int g = 0; g < GROUPS; g++) begin
			fall[g] = (st_reg.pos_d[g] & ~st_reg.s2.group_strobe_pos_n[g]) |
				(st_reg.neg_d[g] & ~st_reg.s2.group_strobe_neg_n[g]);
			if (fall[g] && !st_reg.s2.data_valid_indication_n && !tx_on) begin
				val = st_reg.s2.data_lines_n[g*GRP_W +: GRP_W];
				if (st_reg.s2.group_polarity_flags_n[g]) begin
					val = ~val; // normal: lines are active low
				end
				st_next.asm_b[st_reg.slot[g]][g*GRP_W +: GRP_W] = val;
				st_next.slot[g] = st_reg.slot[g] + XIDX_W'(1);
				set_done[g]     = (st_reg.slot[g] == XIDX_W'(XFERS - 1));
			end
		end
		// hand over once every group holds all four transfers
		if (&st_reg.done) begin
			st_next.rx_valid = 1'b1;
			st_next.rxb      = st_reg.asm_b;
			st_next.done     = set_done; // a new completion wins over the clear
		end else begin
			st_next.done = st_reg.done | set_done;
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_reg          <= '0;
			st_reg.po       <= '1;
			st_reg.prev     <= '1;
			st_reg.tx_ready <= 1'b1;
			st_reg.s1       <= '1;
			st_reg.s2       <= '1;
			st_reg.pos_d    <= '1;
			st_reg.neg_d    <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pin_out  = st_reg.po;
	assign pin_oe   = st_reg.drv_oe;
	assign busy_oe  = st_reg.busy_oe;
	assign tx_ready = st_reg.tx_ready;
	assign rx_valid = st_reg.rx_valid;
	assign rx_block = st_reg.rxb;
endmodule

// processor end: ties the agent core to the processor side of the bus
module qpd_cpu_end (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// bus
	qpd_bus_if.cpu                   bus,
	// transmit side
	input  wire logic                tx_valid,
	input  wire qpd_pkg::qpd_block_t tx_block,
	output logic                     tx_ready,
	// receive side
	output logic                     rx_valid,
	output qpd_pkg::qpd_block_t      rx_block
);
	import qpd_pkg::*;

	// agent on the processor pins
	qpd_agent u_agent (
		.clk      (clk),
		.resetn   (resetn),
		.pin_in   (bus.lines),
		.pin_out  (bus.cpu_out),
		.pin_oe   (bus.cpu_oe),
		.busy_oe  (bus.cpu_busy_oe),
		.tx_valid (tx_valid),
		.tx_block (tx_block),
		.tx_ready (tx_ready),
		.rx_valid (rx_valid),
		.rx_block (rx_block)
	);
endmodule

//--- logic/qpd_hub_end.sv
// hub end of the data bus: same agent behaviour on the hub side pins
// assumes the agent core from the processor-end file is compiled first
`timescale 1ns/1ps
module qpd_hub_end (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                resetn,
	// bus
	qpd_bus_if.hub                   bus,
	// transmit side
	input  wire logic                tx_valid,
	input  wire qpd_pkg::qpd_block_t tx_block,
	output logic                     tx_ready,
	// receive side
	output logic                     rx_valid,
	output qpd_pkg::qpd_block_t      rx_block
);
	import qpd_pkg::*;

	// both agents keep identical data-path duties, so one core serves both
	qpd_agent u_agent (
		.clk      (clk),
		.resetn   (resetn),
		.pin_in   (bus.lines),
		.pin_out  (bus.hub_out),
		.pin_oe   (bus.hub_oe),
		.busy_oe  (bus.hub_busy_oe),
		.tx_valid (tx_valid),
		.tx_block (tx_block),
		.tx_ready (tx_ready),
		.rx_valid (rx_valid),
		.rx_block (rx_block)
	);
endmodule

//--- test/qpd_bus_properties.sv
// wire-level checks on the bus joining the two ends
// assumes qpd_pkg compiled first; instantiated beside the interface
`timescale 1ns/1ps
module qpd_bus_chk (
	// clock and reset
	input wire logic               clk,
	input wire logic               resetn,
	// enables and resolved lines
	input wire logic               cpu_oe,
	input wire logic               hub_oe,
	input wire logic               cpu_busy_oe,
	input wire logic               hub_busy_oe,
	input wire qpd_pkg::qpd_pins_t lines
);
	import qpd_pkg::*;
	wire logic       drv = cpu_oe | hub_oe;
	wire logic       v   = lines.data_valid_indication_n;
	wire logic [3:0] p   = lines.group_strobe_pos_n;
	wire logic [3:0] n   = lines.group_strobe_neg_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// no group may swing more than half its pins
	function automatic bit grp_ok(logic [63:0] a, logic [63:0] b);
		grp_ok = 1'b1;
		for (int g = 0; g < 4; g++) begin
			grp_ok &= ($countones(a[g*16 +: 16] ^ b[g*16 +: 16]) <= 8);
		end
	endfunction
	property p_excl; !(cpu_oe && hub_oe); endproperty
	a_excl: assert property (p_excl) else $error("two drivers");
	property p_vdrv; !v |-> drv; endproperty
	a_vdrv: assert property (p_vdrv) else $error("valid undriven");
	property p_vlen; $fell(v) |-> (!v)[*8] ##1 (!v)[*7] ##1 v; endproperty
	a_vlen: assert property (p_vlen) else $error("valid length");
	property p_stb;
		$fell(v) |-> ##2 (p == 4'h0 && n == 4'hf) ##4 (p == 4'hf && n == 4'h0)
			##4 (p == 4'h0 && n == 4'hf) ##4 (p == 4'hf && n == 4'h0);
	endproperty
	a_stb: assert property (p_stb) else $error("strobe order");
	property p_dbi; drv && !v |-> grp_ok(lines.data_lines_n, $past(lines.data_lines_n)); endproperty
	a_dbi: assert property (p_dbi) else $error("group swing");
	property p_busy; drv |-> !lines.data_bus_in_use_n && (cpu_busy_oe || hub_busy_oe); endproperty
	a_busy: assert property (p_busy) else $error("busy not held");
	property p_tail; $rose(v) |-> drv[*4] ##1 !drv; endproperty
	a_tail: assert property (p_tail) else $error("tail length");
	property p_arb; $rose(drv) |-> $past(lines.data_bus_in_use_n, 2); endproperty
	a_arb: assert property (p_arb) else $error("took busy bus");
	c_cpu: cover property ($fell(v) && cpu_oe);
	c_hub: cover property ($fell(v) && hub_oe);
	c_inv: cover property (!v && lines.group_polarity_flags_n != 4'hf);
endmodule

//--- test/test_quad_pumped_data_bus_slice.sv
// bench: both ends joined, blocks sent each way and compared
// assumes package, interface, ends and checker compiled first
`timescale 1ns/1ps
module test_quad_pumped_data_bus_slice;
	import qpd_pkg::*;
	logic        clk;
	logic        resetn;
	logic        tv [2];
	logic        tr [2];
	logic        rv [2];
	qpd_block_t  tb_b [2];
	qpd_block_t  rb [2];
	qpd_block_t  q [2][$];
	logic [63:0] wq [$];
	logic [15:0] lf;
	logic        pv;
	int          n_mismatch;
	int          total_checks;

	qpd_bus_if qpd_bus_if_i ();
	qpd_cpu_end qpd_cpu_end_i (.clk(clk), .resetn(resetn), .bus(qpd_bus_if_i), .tx_valid(tv[0]),
		.tx_block(tb_b[0]), .tx_ready(tr[0]), .rx_valid(rv[0]), .rx_block(rb[0]));
	qpd_hub_end qpd_hub_end_i (.clk(clk), .resetn(resetn), .bus(qpd_bus_if_i), .tx_valid(tv[1]),
		.tx_block(tb_b[1]), .tx_ready(tr[1]), .rx_valid(rv[1]), .rx_block(rb[1]));
	qpd_bus_chk qpd_bus_chk_i (.clk(clk), .resetn(resetn), .cpu_oe(qpd_bus_if_i.cpu_oe),
		.hub_oe(qpd_bus_if_i.hub_oe), .cpu_busy_oe(qpd_bus_if_i.cpu_busy_oe),
		.hub_busy_oe(qpd_bus_if_i.hub_busy_oe), .lines(qpd_bus_if_i.lines));

	// free-running clock
	always #2 clk = ~clk;

	task chk(string nm, logic [255:0] e, logic [255:0] s);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// sixteen lfsr steps fill one block
	task automatic rnd(output qpd_block_t b);
		for (int i = 0; i < 16; i++) begin
			lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
			b[i/4][(i%4)*16 +: 16] = lf;
		end
	endtask

	// called at a falling edge; request held until taken, then burst awaited
	task automatic send(input int d, input qpd_block_t b);
		int i;
		tb_b[d] = b;
		tv[d] = 1'b1;
		q[d].push_back(b);
		wq.push_back(b[0]);
		for (i = 0; i < 50 && tr[d] !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		tv[d] = 1'b0;
		for (i = 0; i < 60 && tr[d] !== 1'b1; i++) @(negedge clk);
		if (tr[d] !== 1'b1) begin
			n_mismatch++;
			finish_test;
		end
		repeat (2) @(negedge clk);
	endtask

	// receive side and first transfer on the wire, sampled mid-cycle
	always @(negedge clk) begin
		qpd_block_t  e;
		logic [63:0] w;
		logic [63:0] pe;
		logic [3:0]  fe;
		logic        inv;
		for (int d = 0; d < 2; d++) begin
			if (resetn && rv[1-d] === 1'b1) begin
				e = (q[d].size() > 0) ? q[d].pop_front() : 'x;
				chk("rx block", e, rb[1-d]);
			end
		end
		if (pv === 1'b1 && qpd_bus_if_i.lines.data_valid_indication_n === 1'b0) begin
			w = wq.pop_front();
			for (int g = 0; g < 4; g++) begin
				inv = $countones(w[g*16 +: 16]) > 8;
				fe[g] = !inv;
				pe[g*16 +: 16] = inv ? w[g*16 +: 16] : ~w[g*16 +: 16];
			end
			chk("xfer0", {fe, pe}, {qpd_bus_if_i.lines.group_polarity_flags_n,
				qpd_bus_if_i.lines.data_lines_n});
		end
		pv = qpd_bus_if_i.lines.data_valid_indication_n;
	end

	// main sequence: inversion threshold cases, then random traffic both ways
	initial begin
		qpd_block_t b;
		clk = 1'b0;
		resetn = 1'b0;
		tv[0] = 1'b0;
		tv[1] = 1'b0;
		tb_b[0] = '0;
		tb_b[1] = '0;
		lf = 16'h6afa;
		pv = 1'b1;
		n_mismatch = 0;
		total_checks = 0;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		b = {64'h5555_aaaa_5555_aaaa, 64'haaaa_5555_aaaa_5555, 64'hffff_0000_fe00_ff00,
			64'h0000_ffff_01ff_00ff};
		send(0, b);
		send(1, b);
		for (int k = 0; k < 8; k++) begin
			rnd(b);
			send(k / 2 % 2, b);
		end
		repeat (30) @(negedge clk);
		chk("queues", 0, q[0].size() + q[1].size());
		finish_test;
	end
endmodule
